// ===== src/tcc_pkg.sv
package tcc_pkg;

  // Register offsets within the timer page
  localparam logic [7:0] OFF_CAP1_HIGH   = 8'hF0;
  localparam logic [7:0] OFF_CAP1_LOW    = 8'hF1;
  localparam logic [7:0] OFF_CAP2_HIGH   = 8'hF2;
  localparam logic [7:0] OFF_CAP2_LOW    = 8'hF3;
  localparam logic [7:0] OFF_CNT_HIGH    = 8'hF4;
  localparam logic [7:0] OFF_CNT_LOW     = 8'hF5;
  localparam logic [7:0] OFF_MIR_HIGH    = 8'hF6;
  localparam logic [7:0] OFF_MIR_LOW     = 8'hF7;
  localparam logic [7:0] OFF_CMP1_HIGH   = 8'hF8;
  localparam logic [7:0] OFF_CMP1_LOW    = 8'hF9;
  localparam logic [7:0] OFF_CMP2_HIGH   = 8'hFA;
  localparam logic [7:0] OFF_CMP2_LOW    = 8'hFB;
  localparam logic [7:0] OFF_CTRL_ONE    = 8'hFC;
  localparam logic [7:0] OFF_CTRL_TWO    = 8'hFD;
  localparam logic [7:0] OFF_STATUS      = 8'hFE;
  localparam logic [7:0] OFF_CTRL_THREE  = 8'hFF;

  // Reset values and counter maximum
  localparam logic [15:0] CNT_RESET      = 16'hFFFC;
  localparam logic [15:0] CNT_MAX        = 16'hFFFF;
  localparam logic [7:0]  CMP_HIGH_RESET = 8'h80;
  localparam logic [7:0]  CMP_LOW_RESET  = 8'h00;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;

  // Control one fields
  localparam int CAP_IE_BIT   = 7;
  localparam int CMP_IE_BIT   = 6;
  localparam int OVF_IE_BIT   = 5;
  localparam int EDGE1_BIT    = 1;
  // Control two fields
  localparam int ONE_PULSE_BIT = 5;
  localparam int PWM_BIT       = 4;
  localparam int CLK_SEL_LSB   = 2;
  localparam int EDGE2_BIT     = 1;
  localparam int EXT_EDGE_BIT  = 0;
  // Control three fields
  localparam int OVF_SEL_BIT  = 3;
  localparam int CMP_SEL_BIT  = 2;
  localparam int CAP_SEL_BIT  = 1;
  localparam int GLOBAL_BIT   = 0;
  localparam logic [7:0] CTRL_THREE_MASK = 8'h0F;

  // Flag vector positions; status shows them in bits 7..3
  localparam int FLAG_CAP1 = 4;
  localparam int FLAG_CMP1 = 3;
  localparam int FLAG_OVF  = 2;
  localparam int FLAG_CAP2 = 1;
  localparam int FLAG_CMP2 = 0;

  // Prescaler terminal counts, one less than the divide ratio
  localparam logic [2:0] DIV4_LAST = 3'h3;
  localparam logic [2:0] DIV2_LAST = 3'h1;
  localparam logic [2:0] DIV8_LAST = 3'h7;

  typedef enum logic [1:0] {CLK_DIV4, CLK_DIV2, CLK_DIV8, CLK_EXT} clk_sel_e;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic global_req;
    logic capture_req;
    logic compare_req;
    logic overflow_req;
  } irq_s;

endpackage

// ===== src/capture_hold.sv
`timescale 1ns/1ps
// Edge detector and 16-bit latch for one capture input
module capture_hold #(
  parameter int W = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         pin_in,
  input  wire logic         rising_sel,
  input  wire logic [W-1:0] count_in,
  output logic              event_out,
  output logic [W-1:0]      value_q
);

  logic pin_prev_q;

  // Edge select: rising when set, falling otherwise
  assign event_out = rising_sel ? (pin_in & ~pin_prev_q) : (~pin_in & pin_prev_q);

  // Previous pin level
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pin_prev_q <= 1'b0;
    else
      pin_prev_q <= pin_in;
  end

  // Counter snapshot; reset clears it to zero and it holds zero until the first event
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      value_q <= '0;
    else if (event_out)
      value_q <= count_in;
  end

endmodule

// ===== src/timer_capture_compare_regs.sv
`timescale 1ns/1ps
module timer_capture_compare_regs (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire tcc_pkg::reg_req_s bus_req,
  output logic [7:0]            bus_rdata,
  input  wire logic             capture_input_one,
  input  wire logic             capture_input_two,
  input  wire logic             ext_clk_in,
  output tcc_pkg::irq_s         irq_out
);

  logic [7:0]  ctrl1_q, ctrl2_q, ctrl3_q;
  logic [7:0]  cmp1h_q, cmp1l_q, cmp2h_q, cmp2l_q;
  logic [15:0] cnt_q;
  logic [2:0]  presc_q;
  logic        ext_prev_q;
  logic [4:0]  flags_q, armed_q, flags_d, armed_d;
  logic [1:0]  inhibit_q;
  logic [7:0]  rdata_q, rd_mux;
  tcc_pkg::irq_s irq_q, irq_d;

  // Access decode; any read or write counts as an access
  wire       acc       = bus_req.rd | bus_req.wr;
  wire [7:0] a         = bus_req.addr;
  wire       st_acc    = acc && (a == tcc_pkg::OFF_STATUS);
  wire       cl_acc    = acc && (a == tcc_pkg::OFF_CNT_LOW);
  wire       acl_acc   = acc && (a == tcc_pkg::OFF_MIR_LOW);
  wire       c1l_acc   = acc && (a == tcc_pkg::OFF_CAP1_LOW);
  wire       c2l_acc   = acc && (a == tcc_pkg::OFF_CAP2_LOW);
  wire       o1l_acc   = acc && (a == tcc_pkg::OFF_CMP1_LOW);
  wire       o2l_acc   = acc && (a == tcc_pkg::OFF_CMP2_LOW);
  wire       wr_cl     = bus_req.wr && (a == tcc_pkg::OFF_CNT_LOW);
  wire       wr_acl    = bus_req.wr && (a == tcc_pkg::OFF_MIR_LOW);
  wire       wr_o1h    = bus_req.wr && (a == tcc_pkg::OFF_CMP1_HIGH);
  wire       wr_o1l    = bus_req.wr && (a == tcc_pkg::OFF_CMP1_LOW);
  wire       wr_o2h    = bus_req.wr && (a == tcc_pkg::OFF_CMP2_HIGH);
  wire       wr_o2l    = bus_req.wr && (a == tcc_pkg::OFF_CMP2_LOW);
  wire       wr_c1     = bus_req.wr && (a == tcc_pkg::OFF_CTRL_ONE);
  wire       wr_c2     = bus_req.wr && (a == tcc_pkg::OFF_CTRL_TWO);
  wire       wr_c3     = bus_req.wr && (a == tcc_pkg::OFF_CTRL_THREE);

  // Mode bits; PWM takes priority over one-pulse
  wire pwm_on  = ctrl2_q[tcc_pkg::PWM_BIT];
  wire opm_on  = ctrl2_q[tcc_pkg::ONE_PULSE_BIT] & ~pwm_on;
  wire tcc_pkg::clk_sel_e clk_sel =
    tcc_pkg::clk_sel_e'(ctrl2_q[tcc_pkg::CLK_SEL_LSB +: 2]);

  // Timer tick from prescaler or external clock edge
  logic [2:0] div_last;
  always_comb
  begin
    case (clk_sel)
      tcc_pkg::CLK_DIV4: div_last = tcc_pkg::DIV4_LAST;
      tcc_pkg::CLK_DIV2: div_last = tcc_pkg::DIV2_LAST;
      tcc_pkg::CLK_DIV8: div_last = tcc_pkg::DIV8_LAST;
      default:           div_last = tcc_pkg::DIV4_LAST;
    endcase
  end
  wire ext_edge = ctrl2_q[tcc_pkg::EXT_EDGE_BIT] ? (ext_clk_in & ~ext_prev_q)
                                                 : (~ext_clk_in & ext_prev_q);
  wire is_ext   = (clk_sel == tcc_pkg::CLK_EXT);
  wire cnt_tick = is_ext ? ext_edge : (presc_q == div_last);

  // Captures; the second pin flags even when it is only a port output
  logic        cap1_evt, cap2_evt;
  logic [15:0] cap1_val, cap2_val;

  capture_hold #(.W(16)) u_cap_one (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .pin_in     (capture_input_one),
    .rising_sel (ctrl1_q[tcc_pkg::EDGE1_BIT]),
    .count_in   (cnt_q),
    .event_out  (cap1_evt),
    .value_q    (cap1_val)
  );

  capture_hold #(.W(16)) u_cap_two (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .pin_in     (capture_input_two),
    .rising_sel (ctrl2_q[tcc_pkg::EDGE2_BIT]),
    .count_in   (cnt_q),
    .event_out  (cap2_evt),
    .value_q    (cap2_val)
  );

  // Compare matches, held off between high and low byte writes
  wire match1 = cnt_tick && (cnt_q == {cmp1h_q, cmp1l_q}) && !inhibit_q[0];
  wire match2 = cnt_tick && (cnt_q == {cmp2h_q, cmp2l_q}) && !inhibit_q[1];

  // Counter reload: software write, one-pulse trigger, or PWM period end
  wire cnt_reload = wr_cl | wr_acl | (opm_on & cap1_evt) | (pwm_on & match2);
  wire ovf_evt    = cnt_tick && (cnt_q == tcc_pkg::CNT_MAX) && !cnt_reload;

  // Flag sources in status order
  wire [4:0] set_vec = {cap1_evt, match1 & ~pwm_on & ~opm_on, ovf_evt,
                        cap2_evt, match2 & ~pwm_on};
  // Low-byte access per flag; mirror low is absent on purpose
  wire [4:0] low_vec = {c1l_acc, o1l_acc, cl_acc, c2l_acc, o2l_acc};
  wire [4:0] clr_vec = armed_q & low_vec;
  wire [4:0] en_vec  = {ctrl1_q[tcc_pkg::CAP_IE_BIT], ctrl1_q[tcc_pkg::CMP_IE_BIT],
                        ctrl1_q[tcc_pkg::OVF_IE_BIT], ctrl1_q[tcc_pkg::CAP_IE_BIT],
                        ctrl1_q[tcc_pkg::CMP_IE_BIT]};

  // Flag update; a new event beats a clear in the same cycle
  always_comb
  begin
    flags_d = set_vec | (flags_q & ~clr_vec);
    armed_d = st_acc ? flags_q : (armed_q & ~low_vec);
  end

  // Interrupt routing; level OR so the edge channel re-arms only at all-clear
  wire [4:0] gated = flags_q & en_vec;
  wire       glob  = ctrl3_q[tcc_pkg::GLOBAL_BIT];
  always_comb
  begin
    irq_d.global_req   = glob & (|gated);
    irq_d.capture_req  = ~glob & ctrl3_q[tcc_pkg::CAP_SEL_BIT]
                         & (gated[tcc_pkg::FLAG_CAP1] | gated[tcc_pkg::FLAG_CAP2]);
    irq_d.compare_req  = ~glob & ctrl3_q[tcc_pkg::CMP_SEL_BIT]
                         & (gated[tcc_pkg::FLAG_CMP1] | gated[tcc_pkg::FLAG_CMP2]);
    irq_d.overflow_req = ~glob & ctrl3_q[tcc_pkg::OVF_SEL_BIT] & gated[tcc_pkg::FLAG_OVF];
  end

  // Read mux; mirror pair shows the same count as the main pair
  always_comb
  begin
    case (a)
      tcc_pkg::OFF_CAP1_HIGH:  rd_mux = cap1_val[15:8];
      tcc_pkg::OFF_CAP1_LOW:   rd_mux = cap1_val[7:0];
      tcc_pkg::OFF_CAP2_HIGH:  rd_mux = cap2_val[15:8];
      tcc_pkg::OFF_CAP2_LOW:   rd_mux = cap2_val[7:0];
      tcc_pkg::OFF_CNT_HIGH:   rd_mux = cnt_q[15:8];
      tcc_pkg::OFF_CNT_LOW:    rd_mux = cnt_q[7:0];
      tcc_pkg::OFF_MIR_HIGH:   rd_mux = cnt_q[15:8];
      tcc_pkg::OFF_MIR_LOW:    rd_mux = cnt_q[7:0];
      tcc_pkg::OFF_CMP1_HIGH:  rd_mux = cmp1h_q;
      tcc_pkg::OFF_CMP1_LOW:   rd_mux = cmp1l_q;
      tcc_pkg::OFF_CMP2_HIGH:  rd_mux = cmp2h_q;
      tcc_pkg::OFF_CMP2_LOW:   rd_mux = cmp2l_q;
      tcc_pkg::OFF_CTRL_ONE:   rd_mux = ctrl1_q;
      tcc_pkg::OFF_CTRL_TWO:   rd_mux = ctrl2_q;
      tcc_pkg::OFF_STATUS:     rd_mux = {flags_q, 3'b000};
      tcc_pkg::OFF_CTRL_THREE: rd_mux = ctrl3_q;
      default:                 rd_mux = 8'h00;
    endcase
  end

  assign bus_rdata = rdata_q;
  assign irq_out   = irq_q;

  // Counter and prescaler; a reload also restarts the prescaler
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q      <= tcc_pkg::CNT_RESET;
      presc_q    <= '0;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      ext_prev_q <= ext_clk_in;
      presc_q    <= (cnt_reload || cnt_tick || is_ext) ? 3'h0 : presc_q + 3'h1;
      if (cnt_reload)
        cnt_q <= tcc_pkg::CNT_RESET;
      else if (cnt_tick)
        cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Writable registers; read-only offsets have no write path
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl1_q <= tcc_pkg::CTRL_RESET;
      ctrl2_q <= tcc_pkg::CTRL_RESET;
      ctrl3_q <= tcc_pkg::CTRL_RESET;
      cmp1h_q <= tcc_pkg::CMP_HIGH_RESET;
      cmp1l_q <= tcc_pkg::CMP_LOW_RESET;
      cmp2h_q <= tcc_pkg::CMP_HIGH_RESET;
      cmp2l_q <= tcc_pkg::CMP_LOW_RESET;
    end
    else
    begin
      if (wr_c1)  ctrl1_q <= bus_req.wdata;
      if (wr_c2)  ctrl2_q <= bus_req.wdata;
      if (wr_c3)  ctrl3_q <= bus_req.wdata & tcc_pkg::CTRL_THREE_MASK;
      if (wr_o1h) cmp1h_q <= bus_req.wdata;
      if (wr_o1l) cmp1l_q <= bus_req.wdata;
      if (wr_o2h) cmp2h_q <= bus_req.wdata;
      if (wr_o2l) cmp2l_q <= bus_req.wdata;
    end
  end

  // Flags, arming, compare hold-off, read data and requests
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      flags_q   <= '0;
      armed_q   <= '0;
      inhibit_q <= '0;
      rdata_q   <= 8'h00;
      irq_q     <= '0;
    end
    else
    begin
      flags_q   <= flags_d;
      armed_q   <= armed_d;
      inhibit_q <= {(inhibit_q[1] | wr_o2h) & ~wr_o2l, (inhibit_q[0] | wr_o1h) & ~wr_o1l};
      if (bus_req.rd)
        rdata_q <= rd_mux;
      irq_q     <= irq_d;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_arm_ovf;
    st_acc && flags_q[tcc_pkg::FLAG_OVF];
  endsequence
  sequence s_low_ovf;
    cl_acc && !ovf_evt;
  endsequence

  property p_ovf_clear;
    s_arm_ovf ##1 s_low_ovf |=> !flags_q[tcc_pkg::FLAG_OVF];
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

  property p_no_clear_unarmed;
    (cl_acc && !armed_q[tcc_pkg::FLAG_OVF] && flags_q[tcc_pkg::FLAG_OVF])
      |=> flags_q[tcc_pkg::FLAG_OVF];
  endproperty
  a_no_clear_unarmed: assert property (p_no_clear_unarmed) else $error("flag cleared unarmed");

  property p_mirror_keeps;
    (acl_acc && flags_q[tcc_pkg::FLAG_OVF]) |=> flags_q[tcc_pkg::FLAG_OVF];
  endproperty
  a_mirror_keeps: assert property (p_mirror_keeps) else $error("mirror access hit flag");

  property p_cnt_reset;
    (wr_cl || wr_acl) |=> (cnt_q == tcc_pkg::CNT_RESET);
  endproperty
  a_cnt_reset: assert property (p_cnt_reset) else $error("counter not reset by write");

  property p_wrap;
    ovf_evt |=> flags_q[tcc_pkg::FLAG_OVF] && (cnt_q == 16'h0000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap did not set overflow");

  property p_cap1;
    cap1_evt |=> (cap1_val == $past(cnt_q));
  endproperty
  a_cap1: assert property (p_cap1) else $error("first capture value wrong");

  property p_cap2;
    cap2_evt |=> (cap2_val == $past(cnt_q)) ##1 (!glob || !ctrl1_q[tcc_pkg::CAP_IE_BIT]
                                                  || irq_q.global_req);
  endproperty
  a_cap2: assert property (p_cap2) else $error("second capture missed");

  property p_cap2_irq;
    (cap2_evt && glob && ctrl1_q[tcc_pkg::CAP_IE_BIT] && !wr_c1 && !wr_c3)
      |=> ##1 irq_q.global_req;
  endproperty
  a_cap2_irq: assert property (p_cap2_irq) else $error("second capture no request");

  property p_global_only;
    irq_q.global_req |-> !(irq_q.capture_req || irq_q.compare_req || irq_q.overflow_req);
  endproperty
  a_global_only: assert property (p_global_only) else $error("sources not merged");

  property p_all_clear;
    (flags_q == 5'h00) |=> !irq_q.global_req;
  endproperty
  a_all_clear: assert property (p_all_clear) else $error("request with no flag");

  property p_or_req;
    (glob && |gated) |=> irq_q.global_req;
  endproperty
  a_or_req: assert property (p_or_req) else $error("enabled flag gave no request");

  property p_status_low;
    (bus_req.rd && a == tcc_pkg::OFF_STATUS) |=> (bus_rdata[2:0] == 3'b000);
  endproperty
  a_status_low: assert property (p_status_low) else $error("status low bits set");

  property p_cnt_high_rd;
    (bus_req.rd && a == tcc_pkg::OFF_CNT_HIGH) |=> (bus_rdata == $past(cnt_q[15:8]));
  endproperty
  a_cnt_high_rd: assert property (p_cnt_high_rd) else $error("counter high read wrong");

  property p_cmp1_wr;
    wr_o1h |=> (cmp1h_q == $past(bus_req.wdata)) && inhibit_q[0];
  endproperty
  a_cmp1_wr: assert property (p_cmp1_wr) else $error("compare high write lost");

endmodule

// ===== tb/irq_channel_model.sv
`timescale 1ns/1ps
// Edge-triggered interrupt channel as the core sees it
module irq_channel_model (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic req_in,
  input  wire logic rise_trig,
  input  wire logic mask_on,
  input  wire logic pend_clr,
  output logic      pending_q,
  output logic      active,
  output int        edges_q
);
  logic req_q;

  // Only a fresh rising edge pends; a level held high gives nothing more
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      req_q     <= 1'b0;
      pending_q <= 1'b0;
      edges_q   <= 0;
    end
    else
    begin
      req_q <= req_in;
      if (rise_trig && req_in && !req_q)
      begin
        pending_q <= 1'b1;
        edges_q   <= edges_q + 1;
      end
      else if (pend_clr)
        pending_q <= 1'b0;
    end

  // Core acknowledges only while unmasked
  assign active = pending_q && mask_on;
endmodule

// ===== tb/tb_timer_capture_compare_regs.sv
`timescale 1ns/1ps
module tb_timer_capture_compare_regs;
  logic              sys_clk;
  logic              rst;
  tcc_pkg::reg_req_s req;
  logic [7:0]        rdata;
  logic              cap_one;
  logic              cap_two;
  logic              ext_clk;
  tcc_pkg::irq_s     irq;
  logic              rise_trig;
  logic              mask_on;
  logic              pend_clr;
  logic              pending;
  logic              active;
  int                edges;
  logic [7:0]        exp_q[$];
  logic              rd_seen;
  logic [31:0]       lfsr;
  logic [15:0]       cnt;
  int                failures;
  int                n_checks;
  // Counter pair first: it runs at divide by four from reset and wraps soon
  logic [7:0]        ra[11] = '{8'hf4, 8'hf6, 8'hfe, 8'hfc, 8'hfd, 8'hff, 8'hf8, 8'hf9,
                               8'hfa, 8'hfb, 8'h10};
  logic [7:0]        rv[11] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00,
                               8'h80, 8'h00, 8'h00};

  timer_capture_compare_regs timer_capture_compare_regs_inst (
    .sys_clk           (sys_clk),
    .rst               (rst),
    .bus_req           (req),
    .bus_rdata         (rdata),
    .capture_input_one (cap_one),
    .capture_input_two (cap_two),
    .ext_clk_in        (ext_clk),
    .irq_out           (irq)
  );

  irq_channel_model irq_channel_model_inst (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .req_in    (irq.global_req),
    .rise_trig (rise_trig),
    .mask_on   (mask_on),
    .pend_clr  (pend_clr),
    .pending_q (pending),
    .active    (active),
    .edges_q   (edges)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One byte access; a read notes its expected data for the monitor
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    if (!w)
      exp_q.push_back(d);
    req = '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge sys_clk);
    #1;
    req.rd = 1'b0;
    req.wr = 1'b0;
  endtask

  // Full pulses on a pin; slow enough for any input synchroniser
  task automatic pulse(input int sel, input int n);
    repeat (n)
    begin
      for (int v = 1; v >= 0; v--)
      begin
        @(posedge sys_clk);
        #1;
        case (sel)
          0: ext_clk = v[0];
          1: cap_one = v[0];
          default: cap_two = v[0];
        endcase
        repeat (3) @(posedge sys_clk);
      end
      if (sel == 0)
        cnt = cnt + 16'h0001;
    end
  endtask

  task automatic clr_pend();
    @(posedge sys_clk);
    #1 pend_clr = 1'b1;
    @(posedge sys_clk);
    #1 pend_clr = 1'b0;
  endtask

  // Read data lands one cycle after the read is taken
  always @(posedge sys_clk)
    rd_seen <= req.rd;
  always @(negedge sys_clk)
    if (rd_seen && exp_q.size() > 0)
      check(rdata, exp_q.pop_front());

  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    close_out();
  end

  initial
  begin
    req = '0;
    cap_one = 1'b0;
    cap_two = 1'b0;
    ext_clk = 1'b0;
    rise_trig = 1'b0;
    mask_on = 1'b0;
    pend_clr = 1'b0;
    rd_seen = 1'b0;
    failures = 0;
    n_checks = 0;
    lfsr = 32'h20af;
    cnt = 16'h0000;
    rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 rst = 1'b0;
    foreach (ra[i]) bus(0, ra[i], rv[i]);
    $display("test reset values done");
    // External clock mode so each tick is under bench control
    bus(1, 8'hfd, 8'h0f);
    // The free-running count wrapped during the reset reads; the low write below clears it
    bus(0, 8'hfe, 8'h20);
    bus(1, 8'hfc, 8'h02);
    lfsr = next_rand(lfsr);
    bus(1, 8'hf5, lfsr[7:0]);
    cnt = 16'hfffc;
    bus(0, 8'hf5, 8'hfc);
    bus(0, 8'hf7, 8'hfc);
    bus(1, 8'hf4, lfsr[15:8]);
    bus(1, 8'hf0, lfsr[15:8]);
    bus(1, 8'hfe, 8'hf8);
    bus(0, 8'hf4, 8'hff);
    bus(0, 8'hf0, 8'h00);
    bus(0, 8'hfe, 8'h00);
    bus(1, 8'hff, 8'hff);
    bus(0, 8'hff, 8'h0f);
    bus(1, 8'hff, 8'h00);
    pulse(0, 1);
    bus(0, 8'hf5, 8'hfd);
    bus(1, 8'hf7, lfsr[23:16]);
    cnt = 16'hfffc;
    bus(0, 8'hf6, 8'hff);
    bus(0, 8'hf7, 8'hfc);
    $display("test counter access done");
    pulse(0, 4);
    bus(0, 8'hf5, cnt[7:0]);
    bus(0, 8'hfe, 8'h20);
    bus(0, 8'hf7, cnt[7:0]);
    bus(0, 8'hfe, 8'h20);
    bus(0, 8'hf5, cnt[7:0]);
    bus(0, 8'hfe, 8'h00);
    $display("test overflow done");
    pulse(0, 2);
    pulse(1, 1);
    bus(0, 8'hf0, cnt[15:8]);
    bus(0, 8'hf1, cnt[7:0]);
    bus(0, 8'hfe, 8'h80);
    pulse(0, 1);
    pulse(2, 1);
    bus(0, 8'hf2, cnt[15:8]);
    bus(0, 8'hf3, cnt[7:0]);
    bus(0, 8'hfe, 8'h90);
    bus(0, 8'hf1, cnt[7:0] - 8'h01);
    bus(0, 8'hf3, cnt[7:0]);
    bus(0, 8'hfe, 8'h00);
    $display("test captures done");
    lfsr = next_rand(lfsr);
    bus(1, 8'hf8, lfsr[7:0]);
    bus(0, 8'hf8, lfsr[7:0]);
    bus(1, 8'hfa, lfsr[15:8] | 8'h01);
    bus(0, 8'hfa, lfsr[15:8] | 8'h01);
    bus(1, 8'hf8, 8'h00);
    bus(1, 8'hf9, 8'h06);
    pulse(0, 4);
    bus(0, 8'hfe, 8'h40);
    bus(0, 8'hf9, 8'h06);
    bus(0, 8'hfe, 8'h00);
    $display("test compare done");
    // Shared channel brought up in the documented order
    rise_trig = 1'b1;
    bus(1, 8'hff, 8'h01);
    bus(1, 8'hfc, 8'h82);
    clr_pend();
    mask_on = 1'b1;
    pulse(2, 1);
    check(edges[7:0], 8'h01);
    check({7'h00, active}, 8'h01);
    clr_pend();
    pulse(1, 1);
    bus(0, 8'hfe, 8'h90);
    bus(0, 8'hf3, cnt[7:0]);
    pulse(2, 1);
    check(edges[7:0], 8'h01);
    bus(0, 8'hfe, 8'h90);
    bus(0, 8'hf1, cnt[7:0]);
    bus(0, 8'hf3, cnt[7:0]);
    bus(0, 8'hfe, 8'h00);
    check({7'h00, irq.global_req}, 8'h00);
    pulse(2, 1);
    check(edges[7:0], 8'h02);
    $display("test shared interrupt done");
    bus(1, 8'hff, 8'h02);
    repeat (2) @(posedge sys_clk);
    #1;
    check({4'h0, irq.overflow_req, irq.compare_req, irq.capture_req, irq.global_req},
          8'h02);
    bus(1, 8'hff, 8'h03);
    repeat (2) @(posedge sys_clk);
    #1;
    check({4'h0, irq.overflow_req, irq.compare_req, irq.capture_req, irq.global_req},
          8'h01);
    $display("test interrupt routing done");
    repeat (3) @(posedge sys_clk);
    close_out();
  end
endmodule
